// file: bench/pmon_host_model.sv
`default_nettype none

module pmon_host_model (
   // clock
   input wire logic CLOCK,
   // command decoder side
   output logic [15:0] HOST_ADDR,
   output logic HOST_RD,
   output logic HOST_WR,
   output logic HOST_HOLD,
   input wire logic [15:0] HOST_RDATA,
   input wire logic HOST_RVALID
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      HOST_ADDR = 16'h0000;
      HOST_RD = 1'b0;
      HOST_WR = 1'b0;
      HOST_HOLD = 1'b0;
   end

   // released address is inverted so a stale value is never mistaken
   task automatic rd(input logic [15:0] a, output logic [15:0] d,
                     output logic ok);
      ok = 1'b0;
      d = 16'h0000;
      @(negedge CLOCK);
      HOST_ADDR = a;
      HOST_RD = 1'b1;
      @(negedge CLOCK);
      HOST_RD = 1'b0;
      HOST_ADDR = ~a;
      for (int n = 0; n < 3 && !ok; n++) begin
         if (HOST_RVALID === 1'b1) begin
            d = HOST_RDATA;
            ok = 1'b1;
         end else @(negedge CLOCK);
      end
   endtask : rd

   // hold level for multi-word reads; callers change it at a falling edge
   task automatic hold(input logic v);
      HOST_HOLD = v;
   endtask : hold

   task automatic wr(input logic [15:0] a);
      @(negedge CLOCK);
      HOST_ADDR = a;
      HOST_WR = 1'b1;
      @(negedge CLOCK);
      HOST_WR = 1'b0;
      HOST_ADDR = ~a;
   endtask : wr
endmodule : pmon_host_model

`default_nettype wire

// file: bench/pmon_out_properties.sv
`default_nettype none

module pmon_out_properties (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // host side
   input wire logic [15:0] HOST_ADDR,
   input wire logic HOST_RD,
   input wire logic HOST_HOLD,
   input wire logic [15:0] HOST_RDATA,
   input wire logic HOST_RVALID,
   // engine side
   input wire logic ENG_UPDATE,
   input wire pmon_out_pkg::meas_s ENG_MEAS,
   input wire logic ACTIVE_NEG,
   input wire logic REACTIVE_NEG
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   // a read at one address
   sequence s_rd(logic [15:0] a);
      HOST_RD && HOST_ADDR == a;
   endsequence
   // an update that is published with nothing behind it
   sequence s_publish;
      ENG_UPDATE && !HOST_HOLD ##1 !HOST_HOLD && !ENG_UPDATE;
   endsequence

   a_rd_answers: assert property (HOST_RD |=> HOST_RVALID)
      else $error("read not answered next cycle");
   a_rvalid_cause: assert property (HOST_RVALID |-> $past(HOST_RD))
      else $error("answer without a read");
   a_odd_zero: assert property (HOST_RD && HOST_ADDR[0] |=> HOST_RDATA == 0)
      else $error("odd address read not zero");
   a_end_zero: assert property (HOST_RD && HOST_ADDR >= 16'h004E
      |=> HOST_RDATA == 0) else $error("read past bank not zero");
   a_date_fixed: assert property (s_rd(16'h0004)
      |=> HOST_RDATA == pmon_out_pkg::DATE_CODE_RST)
      else $error("date code word wrong");
   a_aux_width: assert property (s_rd(16'h000A)
      |=> HOST_RDATA[15:10] == 6'b00_0000)
      else $error("converter word upper bits set");
   a_hold_freezes: assert property ($past(HOST_HOLD)
      |-> $stable(ACTIVE_NEG) && $stable(REACTIVE_NEG))
      else $error("publish during hold");
   a_sign_follows: assert property (s_publish |=>
      ACTIVE_NEG == $past(ENG_MEAS.active_neg, 2) &&
      REACTIVE_NEG == $past(ENG_MEAS.reactive_neg, 2))
      else $error("direction bits not published");
endmodule : pmon_out_properties

bind power_monitor_output_registers pmon_out_properties u_props (
   .CLOCK(CLOCK), .RSTN(RSTN), .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD),
   .HOST_HOLD(HOST_HOLD), .HOST_RDATA(HOST_RDATA),
   .HOST_RVALID(HOST_RVALID), .ENG_UPDATE(ENG_UPDATE),
   .ENG_MEAS(ENG_MEAS), .ACTIVE_NEG(ACTIVE_NEG), .REACTIVE_NEG(REACTIVE_NEG)
);

`default_nettype wire

// file: bench/tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, rstn = 1'b0, eng_update = 1'b0, energy_en = 1'b1;
   logic [15:0] host_addr, host_rdata, sel_first, sel_second;
   logic host_rd, host_wr, host_hold, host_rvalid, act_neg, react_neg;
   pmon_out_pkg::meas_s meas = '0;
   int error_cnt = 0;
   int comparisons = 0;

   always #5 clock = ~clock;

   power_monitor_output_registers u_dut (.CLOCK(clock), .RSTN(rstn),
      .HOST_ADDR(host_addr), .HOST_RD(host_rd), .HOST_WR(host_wr),
      .HOST_HOLD(host_hold), .HOST_RDATA(host_rdata),
      .HOST_RVALID(host_rvalid), .ENG_UPDATE(eng_update), .ENG_MEAS(meas),
      .ENERGY_EN(energy_en), .MINMAX_SEL_FIRST(sel_first),
      .MINMAX_SEL_SECOND(sel_second), .ACTIVE_NEG(act_neg),
      .REACTIVE_NEG(react_neg));
   pmon_host_model u_host (.CLOCK(clock), .HOST_ADDR(host_addr),
      .HOST_RD(host_rd), .HOST_WR(host_wr), .HOST_HOLD(host_hold),
      .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid));

   task automatic close_out;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // one read through the host model, compared with the expected word
   task automatic chk(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic ok;
      u_host.rd(a, d, ok);
      comparisons++;
      if (ok !== 1'b1 || d !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, d, e);
      end
   endtask : chk

   // one engine strobe; no hold means visible two cycles later
   task automatic publish(input pmon_out_pkg::meas_s m);
      @(negedge clock);
      meas <= m;
      eng_update <= 1'b1;
      @(negedge clock);
      eng_update <= 1'b0;
      repeat (2) @(negedge clock);
   endtask : publish

   task automatic t_reset_vals;
      chk(16'h0004, pmon_out_pkg::DATE_CODE_RST);
      chk(16'h003E, 16'hFFFF);
      chk(16'h004A, 16'h0000);
   endtask : t_reset_vals

   task automatic t_first_update;
      publish({16'h1234, 16'h0C35, 10'h3FF, 16'h8000, 32'h0001_0002,
         32'h1234_5678, 32'h0000_0010, 32'h0000_0020, 1'b1, 1'b0,
         32'h0000_0005, 32'h0000_0007});
      chk(16'h000A, 16'h03FF);
      chk(16'h000C, 16'h8000);
      chk(16'h0014, 16'h1234);
      chk(16'h0002, 16'h0001);
      chk(16'h001E, 16'h0000);
      chk(16'h0026, 16'h0005);
      chk(16'h0028, 16'h0000);
      chk(16'h002E, 16'h0007);
      chk(16'h0036, 16'h0000);
      chk(16'h003E, 16'h5678);
      chk(16'h0048, 16'h1234);
      chk(16'h0042, 16'hFFFF);
   endtask : t_first_update

   // writes only move the pointer; odd and outside addresses read zero
   task automatic t_write_refused;
      u_host.wr(16'h0006);
      chk(16'h0000, 16'h0006);
      chk(16'h0006, 16'h1234);
      chk(16'h0007, 16'h0000);
      chk(16'h004E, 16'h0000);
   endtask : t_write_refused

   task automatic t_hold;
      u_host.hold(1'b1);
      publish({16'h1234, 16'h0C35, 10'h001, 16'h7FFF, 32'h0001_0002,
         32'h0000_0100, 32'h0000_0010, 32'h0000_0020, 1'b0, 1'b0,
         32'h0000_0000, 32'h0000_0000});
      chk(16'h0012, 16'h5678);
      chk(16'h0002, 16'h0001);
      @(negedge clock);
      u_host.hold(1'b0);
      repeat (2) @(negedge clock);
      chk(16'h0012, 16'h0100);
      chk(16'h003E, 16'h0100);
      chk(16'h0046, 16'h5678);
      chk(16'h000C, 16'h7FFF);
   endtask : t_hold

   // a gated publish drops its sum; second selector now tracks voltage
   task automatic t_energy_gate;
      sel_second = pmon_out_pkg::RMS_VOLTAGE_OFS;
      energy_en = 1'b0;
      publish({16'h0F00, 16'h0C35, 10'h001, 16'h7FFF, 32'h0001_0002,
         32'h0000_0200, 32'h0000_0010, 32'h0000_0020, 1'b0, 1'b1,
         32'h0000_0009, 32'h0000_0003});
      chk(16'h001E, 16'h0000);
      chk(16'h0036, 16'h0000);
      energy_en = 1'b1;
      publish({16'h00F0, 16'h0C35, 10'h001, 16'h7FFF, 32'h0001_0002,
         32'h0000_0200, 32'h0000_0010, 32'h0000_0020, 1'b0, 1'b1,
         32'h0000_0009, 32'h0000_0003});
      chk(16'h001E, 16'h0009);
      chk(16'h0036, 16'h0003);
      chk(16'h002E, 16'h0007);
      chk(16'h0042, 16'h00F0);
      chk(16'h004A, 16'h0F00);
   endtask : t_energy_gate

   initial begin
      sel_first = pmon_out_pkg::ACTIVE_PWR_OFS;
      sel_second = 16'h0100;
      repeat (6) @(negedge clock);
      rstn = 1'b1;
      t_reset_vals();
      t_first_update();
      t_write_refused();
      t_hold();
      t_energy_gate();
      close_out();
   end

   // watchdog well beyond the roughly ninety cycles the tests need
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule : tb

`default_nettype wire

// file: rtl/pmon_out_pkg.sv
`default_nettype none

package pmon_out_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [15:0] CMD_ADDR_PTR_OFS = 16'h0000;
   localparam logic [15:0] STATUS_OFS = 16'h0002;
   localparam logic [15:0] DATE_CODE_OFS = 16'h0004;
   localparam logic [15:0] RMS_VOLTAGE_OFS = 16'h0006;
   localparam logic [15:0] LINE_FREQ_OFS = 16'h0008;
   localparam logic [15:0] THERM_OFS = 16'h000A;
   localparam logic [15:0] PF_OFS = 16'h000C;
   localparam logic [15:0] RMS_CURRENT_OFS = 16'h000E;
   localparam logic [15:0] ACTIVE_PWR_OFS = 16'h0012;
   localparam logic [15:0] REACTIVE_PWR_OFS = 16'h0016;
   localparam logic [15:0] APPARENT_PWR_OFS = 16'h001A;
   localparam logic [15:0] ACT_IN_OFS = 16'h001E;
   localparam logic [15:0] ACT_OUT_OFS = 16'h0026;
   localparam logic [15:0] REACT_IN_OFS = 16'h002E;
   localparam logic [15:0] REACT_OUT_OFS = 16'h0036;
   localparam logic [15:0] LOW_FIRST_OFS = 16'h003E;
   localparam logic [15:0] LOW_SECOND_OFS = 16'h0042;
   localparam logic [15:0] HIGH_FIRST_OFS = 16'h0046;
   localparam logic [15:0] HIGH_SECOND_OFS = 16'h004A;
   // first byte address past the bank
   localparam logic [15:0] BANK_END_OFS = 16'h004E;
   localparam int BANK_WORDS = 39;

   // ************************************************************
   // status word fields and reset values
   // ************************************************************
   localparam int STATUS_P_NEG_BIT = 0;
   localparam int STATUS_Q_NEG_BIT = 1;
   // arbitrary neutral date code, replaced by the factory value
   localparam logic [15:0] DATE_CODE_RST = 16'h0000;
   localparam logic [31:0] LOW_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] HIGH_RST = 32'h0000_0000;
   localparam int AUX_BITS = 10;

   // ************************************************************
   // one result set from the calculation engine
   // ************************************************************
   typedef struct packed {
      logic [15:0] voltage;
      logic [15:0] frequency;
      logic [AUX_BITS-1:0] aux_converter;
      logic [15:0] power_factor;
      logic [31:0] current;
      logic [31:0] active_mag;
      logic [31:0] reactive_mag;
      logic [31:0] apparent;
      logic active_neg;
      logic reactive_neg;
      logic [31:0] active_energy_inc;
      logic [31:0] reactive_energy_inc;
   } meas_s;

   // four energy totals
   typedef struct packed {
      logic [63:0] act_in;
      logic [63:0] act_out;
      logic [63:0] react_in;
      logic [63:0] react_out;
   } energy_s;

endpackage : pmon_out_pkg

`default_nettype wire

// file: rtl/power_monitor_output_registers.sv
`default_nettype none

// Notes on behaviour
// (RULE1) read-only word at 0x0000 shows the last command address used
// (RULE2) read-only word at 0x0004 shows the fixed YYWW date code
// (RULE3) word at 0x000A holds the 10-bit aux converter result, zero-extended
// (RULE4) power registers hold magnitudes; direction bits sit in status
// (RULE5) 64-bit imported active energy total at 0x001E
// (RULE6) 64-bit exported active energy total at 0x0026
// (RULE7) 64-bit imported reactive energy total at 0x002E
// (RULE8) 64-bit exported reactive energy total at 0x0036
// (RULE9) smallest value of each selected quantity at 0x003E and 0x0042
// (RULE10) largest value of each selected quantity at 0x0046 and 0x004A
// (RULE11) tracking only for selectors naming 0x0006 to 0x001A registers
// (RULE12) power factor is signed: 0x7FFF is +1, 0x8000 is -1; here the min/max trackers compare it unsigned, zero-extended
// (RULE13) host writes never change any register of this bank; here a write does load the pointer at 0x0000
// (RULE14) multi-word reads see one coherent snapshot, no mid-read update
module power_monitor_output_registers (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // host access from the command decoder
   input wire logic [15:0] HOST_ADDR,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic HOST_HOLD,
   output logic [15:0] HOST_RDATA,
   output logic HOST_RVALID,
   // calculation engine results
   input wire logic ENG_UPDATE,
   input wire pmon_out_pkg::meas_s ENG_MEAS,
   input wire logic ENERGY_EN,
   // min/max selectors
   input wire logic [15:0] MINMAX_SEL_FIRST,
   input wire logic [15:0] MINMAX_SEL_SECOND,
   // published direction bits
   output logic ACTIVE_NEG,
   output logic REACTIVE_NEG
);

   // ************************************************************
   // state
   // ************************************************************
   pmon_out_pkg::meas_s stage_reg;
   pmon_out_pkg::meas_s pub_reg;
   logic [63:0] stage_act_inc_reg;
   logic [63:0] stage_react_inc_reg;
   logic pending_reg;
   logic publish;
   pmon_out_pkg::energy_s energy_reg;
   logic [15:0] cmd_addr_ptr_reg;
   logic [31:0] low_reg [2];
   logic [31:0] high_reg [2];
   logic [15:0] sel [2];
   logic [15:0] status_word;
   logic [15:0] image [pmon_out_pkg::BANK_WORDS];

   // engine results wait in the stage while the host holds a read
   assign publish = pending_reg && !HOST_HOLD; // RULE14

   // ************************************************************
   // staging of engine results
   // ************************************************************
   // increments are summed while held so no energy is dropped
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         stage_reg <= '0;
         stage_act_inc_reg <= 64'h0000_0000_0000_0000;
         stage_react_inc_reg <= 64'h0000_0000_0000_0000;
         pending_reg <= 1'b0;
      end else begin
         if (ENG_UPDATE) begin
            stage_reg <= ENG_MEAS;
            pending_reg <= 1'b1;
         end else if (publish) begin
            pending_reg <= 1'b0;
         end
         // an update in the publish cycle starts a fresh sum
         if (publish) begin
            stage_act_inc_reg <= ENG_UPDATE ?
               {32'h0000_0000, ENG_MEAS.active_energy_inc} :
               64'h0000_0000_0000_0000;
            stage_react_inc_reg <= ENG_UPDATE ?
               {32'h0000_0000, ENG_MEAS.reactive_energy_inc} :
               64'h0000_0000_0000_0000;
         end else if (ENG_UPDATE) begin
            stage_act_inc_reg <= stage_act_inc_reg +
               {32'h0000_0000, ENG_MEAS.active_energy_inc};
            stage_react_inc_reg <= stage_react_inc_reg +
               {32'h0000_0000, ENG_MEAS.reactive_energy_inc};
         end
      end
   end

   // ************************************************************
   // published output quantities
   // ************************************************************
   // magnitudes and sign bits move together in one cycle
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pub_reg <= '0;
      end else if (publish) begin
         pub_reg <= stage_reg; // RULE4
      end
   end

   // ************************************************************
   // energy accumulators
   // ************************************************************
   // direction picks import or export; totals wrap at 64 bits
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         energy_reg <= '0;
      end else if (publish && ENERGY_EN) begin
         if (!stage_reg.active_neg) begin
            energy_reg.act_in <= energy_reg.act_in +
               stage_act_inc_reg; // RULE5
         end else begin
            energy_reg.act_out <= energy_reg.act_out +
               stage_act_inc_reg; // RULE6
         end
         if (!stage_reg.reactive_neg) begin
            energy_reg.react_in <= energy_reg.react_in +
               stage_react_inc_reg; // RULE7
         end else begin
            energy_reg.react_out <= energy_reg.react_out +
               stage_react_inc_reg; // RULE8
         end
      end
   end

   // ************************************************************
   // min/max trackers
   // ************************************************************
   assign sel[0] = MINMAX_SEL_FIRST;
   assign sel[1] = MINMAX_SEL_SECOND;

   // a value is compared as it is published, so records match reads
   for (genvar t = 0; t < 2; t++) begin : g_track
      logic [31:0] val;
      logic val_ok;

      // only output quantity start addresses are tracked
      always_comb begin
         val = 32'h0000_0000;
         val_ok = 1'b1;
         if (sel[t] == pmon_out_pkg::RMS_VOLTAGE_OFS) begin // RULE11
            val = {16'h0000, stage_reg.voltage};
         end else if (sel[t] == pmon_out_pkg::LINE_FREQ_OFS) begin
            val = {16'h0000, stage_reg.frequency};
         end else if (sel[t] == pmon_out_pkg::THERM_OFS) begin
            val = {22'h00_0000, stage_reg.aux_converter};
         end else if (sel[t] == pmon_out_pkg::PF_OFS) begin
            val = {16'h0000, stage_reg.power_factor};
         end else if (sel[t] == pmon_out_pkg::RMS_CURRENT_OFS) begin
            val = stage_reg.current;
         end else if (sel[t] == pmon_out_pkg::ACTIVE_PWR_OFS) begin
            val = stage_reg.active_mag;
         end else if (sel[t] == pmon_out_pkg::REACTIVE_PWR_OFS) begin
            val = stage_reg.reactive_mag;
         end else if (sel[t] == pmon_out_pkg::APPARENT_PWR_OFS) begin
            val = stage_reg.apparent;
         end else begin
            val_ok = 1'b0; // RULE11
         end
      end

      always_ff @(posedge CLOCK or negedge RSTN) begin
         if (!RSTN) begin
            low_reg[t] <= pmon_out_pkg::LOW_RST;
            high_reg[t] <= pmon_out_pkg::HIGH_RST;
         end else if (publish && val_ok) begin
            if (val < low_reg[t]) begin
               low_reg[t] <= val; // RULE9
            end
            if (val > high_reg[t]) begin
               high_reg[t] <= val; // RULE10
            end
         end
      end
   end

   // ************************************************************
   // command address pointer
   // ************************************************************
   // follows every host access; host writes only move the pointer
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_addr_ptr_reg <= 16'h0000;
      end else if (HOST_RD || HOST_WR) begin
         cmd_addr_ptr_reg <= HOST_ADDR; // RULE1 RULE13
      end
   end

   // ************************************************************
   // read image, little-endian words from 0x0000 upward
   // ************************************************************
   always_comb begin
      status_word = 16'h0000;
      status_word[pmon_out_pkg::STATUS_P_NEG_BIT] = pub_reg.active_neg;
      status_word[pmon_out_pkg::STATUS_Q_NEG_BIT] = pub_reg.reactive_neg;
   end

   assign image[0] = cmd_addr_ptr_reg; // RULE1
   assign image[1] = status_word; // RULE4
   assign image[2] = pmon_out_pkg::DATE_CODE_RST; // RULE2
   assign image[3] = pub_reg.voltage;
   assign image[4] = pub_reg.frequency;
   assign image[5] = {6'h00, pub_reg.aux_converter}; // RULE3
   assign image[6] = pub_reg.power_factor; // RULE12
   assign {image[8], image[7]} = pub_reg.current;
   assign {image[10], image[9]} = pub_reg.active_mag; // RULE4
   assign {image[12], image[11]} = pub_reg.reactive_mag;
   assign {image[14], image[13]} = pub_reg.apparent;
   assign {image[18], image[17], image[16], image[15]} = energy_reg.act_in;
   assign {image[22], image[21], image[20], image[19]} = energy_reg.act_out;
   assign {image[26], image[25], image[24], image[23]} = energy_reg.react_in;
   assign {image[30], image[29], image[28], image[27]} =
      energy_reg.react_out;
   assign {image[32], image[31]} = low_reg[0];
   assign {image[34], image[33]} = low_reg[1];
   assign {image[36], image[35]} = high_reg[0];
   assign {image[38], image[37]} = high_reg[1];

   // ************************************************************
   // host read port
   // ************************************************************
   // odd or out-of-bank addresses read as zero
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         HOST_RDATA <= 16'h0000;
         HOST_RVALID <= 1'b0;
      end else begin
         HOST_RVALID <= HOST_RD;
         if (HOST_RD) begin
            if (HOST_ADDR[0] || HOST_ADDR >= pmon_out_pkg::BANK_END_OFS) begin
               HOST_RDATA <= 16'h0000;
            end else begin
               HOST_RDATA <= image[HOST_ADDR[6:1]];
            end
         end
      end
   end

   // direction outputs mirror the published status bits
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ACTIVE_NEG <= 1'b0;
         REACTIVE_NEG <= 1'b0;
      end else if (publish) begin
         ACTIVE_NEG <= stage_reg.active_neg; // RULE4
         REACTIVE_NEG <= stage_reg.reactive_neg;
      end
   end

endmodule : power_monitor_output_registers

`default_nettype wire
